// [verilog/tpso_defs.svh]
// constants for the trimmed power-on sequence option block
`ifndef TPSO_DEFS_SVH
`define TPSO_DEFS_SVH
// ----------------------------------------------------------------
// clock rates and timing
// ----------------------------------------------------------------
`define TPSO_REF_HZ          200000000
`define TPSO_OSC_HZ          32000
`define TPSO_OSC_KHZ         32
`define TPSO_OSC_TOL_PCT     20
`define TPSO_C12_VALID_US    2000
// least 2 ms counted on the fastest oscillator, rounded up
`define TPSO_C12_VALID_TICKS ((`TPSO_C12_VALID_US*`TPSO_OSC_KHZ*(100+`TPSO_OSC_TOL_PCT)+99999)/100000)
// sequence step points in oscillator ticks
`define TPSO_STEP_LDO_TICKS  8'h02
`define TPSO_STEP_CONV_TICKS 8'h04
`define TPSO_STEP_RST_TICKS  8'h28
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TPSO_ADDR_LDO_ON     4'h0
`define TPSO_ADDR_ILIM       4'h1
`define TPSO_ADDR_ICHG       4'h2
`define TPSO_ADDR_STATUS     4'h3
// ----------------------------------------------------------------
// field codes and reset values
// ----------------------------------------------------------------
`define TPSO_LDO_ON_ALL      3'h7
`define TPSO_LDO_ON_NONE     3'h0
`define TPSO_ILIM_720MA      4'h5
`define TPSO_ILIM_1200MA     4'h9
`define TPSO_ICHG_500MA      4'h4
`define TPSO_ICHG_900MA      4'h8
`define TPSO_STAT_OPT_LSB    3
`define TPSO_STAT_RST_BIT    5
`define TPSO_STAT_C12_BIT    6
`define TPSO_STAT_INIT_BIT   7
`endif

// [verilog/tpso_pkg.sv]
// types for the trimmed power-on sequence option block
package tpso_pkg;
  // ----------------------------------------------------------------
  // sequence options as trimmed
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OPT_SEQ1 = 2'h0,
    OPT_SEQ2 = 2'h1,
    OPT_SEQ3 = 2'h2,
    OPT_SEQ4 = 2'h3
  } tpso_opt_type;
  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_SEQ = 3'h2,
    ST_ON  = 3'h4
  } tpso_state_type;
  // ----------------------------------------------------------------
  // rail enables travelling together
  // ----------------------------------------------------------------
  typedef struct packed {
    logic conv12;  // first/second converter enable
    logic conv3;   // third converter enable
    logic lreg2;   // second linear regulator enable
    logic vref;    // reference enable
  } tpso_rails_type;
endpackage

// [verilog/tpso_top.sv]
// trimmed power-on sequence option logic with its register port
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tpso_defs.svh"

module tpso_top
#(
  parameter int unsigned TICK_DIV = `TPSO_REF_HZ / `TPSO_OSC_HZ  // ref cycles per osc tick
)
(
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RESETN_I,
  input  wire logic [1:0]              TRIM_SEL_I,
  input  wire logic                    PWR_ON_REQ_I,
  input  wire logic                    PWR_OFF_REQ_I,
  input  wire logic                    CHG_SUPPLY_I,
  input  wire logic                    CONV12_EN_IN_I,
  input  wire logic                    CONV3_EN_IN_I,
  input  wire logic [3:0]              ADDR_I,
  input  wire logic [7:0]              WDATA_I,
  input  wire logic                    WR_I,
  input  wire logic                    RD_I,
  output logic      [7:0]              RDATA_O,
  output tpso_pkg::tpso_rails_type     RAILS_O,
  output logic                         SYS_RESET_N_O,
  output logic      [2:0]              LDO_ON_O,
  output logic      [3:0]              ILIM_O,
  output logic      [3:0]              ICHG_O
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned C12_TICKS = `TPSO_C12_VALID_TICKS;  // 77 ticks

  tpso_pkg::tpso_opt_type   opt_r;        // latched trim option
  logic                     init_done_r;  // trim caught, defaults loaded
  tpso_pkg::tpso_state_type state_r;      // sequencer state
  tpso_pkg::tpso_state_type state_nxt;
  logic [12:0]              div_r;        // ref to osc divider
  logic                     tick;         // one-cycle osc tick enable
  logic [7:0]               step_r;       // ticks since power-on start
  logic [7:0]               elap_r;       // saturating elapsed ticks
  logic                     chg_d_r;      // charger level one cycle back
  logic                     chg_rise;     // charger supply appeared
  logic                     on_start;     // power-on start condition
  logic                     rst_n_r;      // system reset out, low active
  logic                     seq_ldo_on;   // sequence step: regulator two and ref
  logic                     seq_conv_on;  // sequence step: converters
  logic                     c12_valid;    // converter12 pin honoured
  logic                     c3_valid;     // converter3 pin honoured
  logic                     opt4;         // option four selected
  logic [2:0]               ldo_on_r;     // LDO3..5 on bits
  logic [3:0]               ilim_r;       // input current limit field
  logic [3:0]               ichg_r;       // charge current field
  logic [7:0]               rdata_r;      // registered read data

  // ----------------------------------------------------------------
  // reset defaults per option
  // ----------------------------------------------------------------
  // default LDO3..5 on bits for a given option
  function automatic logic [2:0] ldo_dflt(input tpso_pkg::tpso_opt_type o);
    ldo_dflt = (o == tpso_pkg::OPT_SEQ4) ? `TPSO_LDO_ON_NONE : `TPSO_LDO_ON_ALL;
  endfunction

  // default input current limit code for a given option
  function automatic logic [3:0] ilim_dflt(input tpso_pkg::tpso_opt_type o);
    ilim_dflt = (o == tpso_pkg::OPT_SEQ3) ? `TPSO_ILIM_1200MA : `TPSO_ILIM_720MA;
  endfunction

  // default charge current code for a given option
  function automatic logic [3:0] ichg_dflt(input tpso_pkg::tpso_opt_type o);
    ichg_dflt = (o == tpso_pkg::OPT_SEQ3) ? `TPSO_ICHG_900MA : `TPSO_ICHG_500MA;
  endfunction

  // ----------------------------------------------------------------
  // trim capture
  // ----------------------------------------------------------------
  // the strap is caught at the first edge after reset release, never
  // by the reset itself; after that it stays put until the next reset
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      opt_r       <= tpso_pkg::OPT_SEQ1;
      init_done_r <= 1'b0;
    end
    else if (!init_done_r)
    begin
      opt_r       <= tpso_pkg::tpso_opt_type'(TRIM_SEL_I);
      init_done_r <= 1'b1;
    end
  end

  assign opt4 = (opt_r == tpso_pkg::OPT_SEQ4);

  // ----------------------------------------------------------------
  // oscillator tick divider
  // ----------------------------------------------------------------
  // one clock only: the 32 kHz rate is a single-cycle enable
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      div_r <= 13'h0000;
    else if (div_r == 13'(TICK_DIV - 1))
      div_r <= 13'h0000;
    else
      div_r <= div_r + 13'h0001;
  end

  assign tick = (div_r == 13'(TICK_DIV - 1));

  // ----------------------------------------------------------------
  // power-on start detection
  // ----------------------------------------------------------------
  // inputs are synchronous, so a plain delayed copy finds the edge
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      chg_d_r <= 1'b0;
    else
      chg_d_r <= CHG_SUPPLY_I;
  end

  assign chg_rise = CHG_SUPPLY_I & ~chg_d_r;
  // charger insertion only counts when the option allows it
  assign on_start = init_done_r & (PWR_ON_REQ_I | (chg_rise & ~opt4));

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  // next state; off request wins over everything
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      tpso_pkg::ST_OFF:
      begin
        if (on_start && !PWR_OFF_REQ_I)
          state_nxt = tpso_pkg::ST_SEQ;
      end
      tpso_pkg::ST_SEQ:
      begin
        if (PWR_OFF_REQ_I)
          state_nxt = tpso_pkg::ST_OFF;
        else if (tick && step_r == `TPSO_STEP_RST_TICKS - 8'h01)
          state_nxt = tpso_pkg::ST_ON;
      end
      tpso_pkg::ST_ON:
      begin
        if (PWR_OFF_REQ_I)
          state_nxt = tpso_pkg::ST_OFF;
      end
      default:
        state_nxt = tpso_pkg::ST_OFF;
    endcase
  end

  // state register
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      state_r <= tpso_pkg::ST_OFF;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // step and elapsed counters
  // ----------------------------------------------------------------
  // step counter runs through the sequence; it stops at the release
  // point so the steps stay asserted while on
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      step_r <= 8'h00;
    else if (state_r == tpso_pkg::ST_OFF)
      step_r <= 8'h00;
    else if (tick && step_r != `TPSO_STEP_RST_TICKS)
      step_r <= step_r + 8'h01;
  end

  // elapsed ticks since power-on start, saturating at the 2 ms point;
  // the count uses the fast corner so 2 ms holds on every part
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      elap_r <= 8'h00;
    else if (state_r == tpso_pkg::ST_OFF)
      elap_r <= 8'h00;
    else if (tick && elap_r != 8'(C12_TICKS))
      elap_r <= elap_r + 8'h01;
  end

  // ----------------------------------------------------------------
  // sequence steps and system reset
  // ----------------------------------------------------------------
  assign seq_ldo_on  = (state_r != tpso_pkg::ST_OFF) && (step_r >= `TPSO_STEP_LDO_TICKS);
  assign seq_conv_on = (state_r != tpso_pkg::ST_OFF) && (step_r >= `TPSO_STEP_CONV_TICKS);

  // system reset out is held low until the sequence completes
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rst_n_r <= 1'b0;
    else
      rst_n_r <= (state_nxt == tpso_pkg::ST_ON);
  end

  // ----------------------------------------------------------------
  // converter pin gating and rail enables
  // ----------------------------------------------------------------
  // before the pin counts, the converter simply follows the sequence
  always_comb
  begin
    case (opt_r)
      tpso_pkg::OPT_SEQ1: c12_valid = (elap_r == 8'(C12_TICKS));
      default:            c12_valid = rst_n_r;
    endcase
    c3_valid = opt4 & rst_n_r;
  end

  // rail outputs; a converter held off by the pin stays off only
  // while its pin is low, the sequence alone never forces it off late
  always_comb
  begin
    RAILS_O.conv12 = seq_conv_on & (~c12_valid | CONV12_EN_IN_I);
    RAILS_O.conv3  = seq_conv_on & (~c3_valid | CONV3_EN_IN_I);
    RAILS_O.lreg2  = opt4 | seq_ldo_on;
    RAILS_O.vref   = opt4 | seq_ldo_on;
  end

  assign SYS_RESET_N_O = rst_n_r;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // defaults follow the option and load at the trim capture edge;
  // writes before that edge are dropped
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      ldo_on_r <= `TPSO_LDO_ON_NONE;
      ilim_r   <= `TPSO_ILIM_720MA;
      ichg_r   <= `TPSO_ICHG_500MA;
    end
    else if (!init_done_r)
    begin
      ldo_on_r <= ldo_dflt(tpso_pkg::tpso_opt_type'(TRIM_SEL_I));
      ilim_r   <= ilim_dflt(tpso_pkg::tpso_opt_type'(TRIM_SEL_I));
      ichg_r   <= ichg_dflt(tpso_pkg::tpso_opt_type'(TRIM_SEL_I));
    end
    else if (WR_I)
    begin
      if (ADDR_I == `TPSO_ADDR_LDO_ON)
        ldo_on_r <= WDATA_I[2:0];
      else if (ADDR_I == `TPSO_ADDR_ILIM)
        ilim_r <= WDATA_I[3:0];
      else if (ADDR_I == `TPSO_ADDR_ICHG)
        ichg_r <= WDATA_I[3:0];
    end
  end

  // read data, valid the cycle after the strobe, zero otherwise
  always_ff @(posedge REF_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      rdata_r <= 8'h00;
    else if (!RD_I)
      rdata_r <= 8'h00;
    else if (ADDR_I == `TPSO_ADDR_LDO_ON)
      rdata_r <= {5'h00, ldo_on_r};
    else if (ADDR_I == `TPSO_ADDR_ILIM)
      rdata_r <= {4'h0, ilim_r};
    else if (ADDR_I == `TPSO_ADDR_ICHG)
      rdata_r <= {4'h0, ichg_r};
    else if (ADDR_I == `TPSO_ADDR_STATUS)
      rdata_r <= {init_done_r, c12_valid, rst_n_r, opt_r, state_r};
    else
      rdata_r <= 8'h00;  // unmapped reads zero
  end

  assign RDATA_O  = rdata_r;
  assign LDO_ON_O = ldo_on_r;
  assign ILIM_O   = ilim_r;
  assign ICHG_O   = ichg_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  property p_opt_static;
    init_done_r && $past(init_done_r) |-> $stable(opt_r);
  endproperty
  a_opt_static: assert property (p_opt_static) else $error("option changed");

  property p_c12_early;
    opt_r == tpso_pkg::OPT_SEQ1 && seq_conv_on && elap_r < 8'(C12_TICKS) |-> RAILS_O.conv12;
  endproperty
  a_c12_early: assert property (p_c12_early) else $error("pin acted before 2ms");

  property p_c12_rst;
    opt_r != tpso_pkg::OPT_SEQ1 && seq_conv_on && !rst_n_r |-> RAILS_O.conv12;
  endproperty
  a_c12_rst: assert property (p_c12_rst) else $error("pin acted in reset");

  property p_c3_ignored;
    init_done_r && !opt4 |-> RAILS_O.conv3 == seq_conv_on;
  endproperty
  a_c3_ignored: assert property (p_c3_ignored) else $error("conv3 pin honoured");

  property p_opt4_pins;
    opt4 && rst_n_r && !CONV3_EN_IN_I && !CONV12_EN_IN_I |-> !RAILS_O.conv3 && !RAILS_O.conv12;
  endproperty
  a_opt4_pins: assert property (p_opt4_pins) else $error("pins ignored");

  property p_ldo_seq;
    init_done_r && !opt4 && state_r == tpso_pkg::ST_OFF |-> !RAILS_O.lreg2 && !RAILS_O.vref;
  endproperty
  a_ldo_seq: assert property (p_ldo_seq) else $error("regulator two on outside sequence");

  property p_ldo_always;
    init_done_r && opt4 |-> RAILS_O.lreg2 && RAILS_O.vref;
  endproperty
  a_ldo_always: assert property (p_ldo_always) else $error("regulator two not on");

  property p_ldo_dflt;
    $rose(init_done_r) |-> LDO_ON_O == (opt4 ? `TPSO_LDO_ON_NONE : `TPSO_LDO_ON_ALL);
  endproperty
  a_ldo_dflt: assert property (p_ldo_dflt) else $error("ldo default wrong");

  property p_chg_block;
    opt4 && state_r == tpso_pkg::ST_OFF && !PWR_ON_REQ_I |=> state_r == tpso_pkg::ST_OFF;
  endproperty
  a_chg_block: assert property (p_chg_block) else $error("charger started power");
  property p_ilim_dflt;
    $rose(init_done_r) |->
      ILIM_O == (opt_r == tpso_pkg::OPT_SEQ3 ? `TPSO_ILIM_1200MA : `TPSO_ILIM_720MA);
  endproperty
  a_ilim_dflt: assert property (p_ilim_dflt) else $error("ilim default wrong");
  property p_ichg_dflt;
    $rose(init_done_r) |->
      ICHG_O == (opt_r == tpso_pkg::OPT_SEQ3 ? `TPSO_ICHG_900MA : `TPSO_ICHG_500MA);
  endproperty
  a_ichg_dflt: assert property (p_ichg_dflt) else $error("ichg default wrong");

  property p_tick_gap;
    tick |=> !tick [*2];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

  c_chg_on: cover property (state_r == tpso_pkg::ST_OFF && chg_rise ##1 state_r == tpso_pkg::ST_SEQ);
  c_reach_on: cover property ($rose(rst_n_r));
  c_opt4_c3: cover property (opt4 && rst_n_r && $fell(RAILS_O.conv3));
  c_opt1_valid: cover property (opt_r == tpso_pkg::OPT_SEQ1 && $rose(c12_valid));

endmodule // tpso_top

// [tb/tpso_host_model.sv]
// host processor model driving the converter enable pins
`timescale 1ns/1ps

module tpso_host_model
(
  input  wire logic       clk_i,         // reference clock
  input  wire logic       resetn_i,      // async reset, active low
  input  wire logic [1:0] lag_i,         // answer delay in cycles, 0 is prompt
  input  wire logic       conv12_req_i,  // wanted level of converter12 pin
  input  wire logic       conv3_req_i,   // wanted level of converter3 pin
  output logic            conv12_en_o,   // converter12_enable_in pin
  output logic            conv3_en_o     // converter3_enable_in pin
);
  // ----------------------------------------------------------------
  // delay lines
  // ----------------------------------------------------------------
  logic [2:0] c12_r;  // past wanted levels, oldest on top
  logic [2:0] c3_r;   // same for converter3

  // pins change only just after an edge, as real firmware writes a gpio
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      c12_r <= 3'h0;
      c3_r  <= 3'h0;
    end
    else
    begin
      c12_r <= {c12_r[1:0], conv12_req_i};
      c3_r  <= {c3_r[1:0], conv3_req_i};
    end
  end

  // a slow host answers late; both pins share one lag
  assign conv12_en_o = (lag_i == 2'h0) ? conv12_req_i : c12_r[lag_i - 2'h1];
  assign conv3_en_o  = (lag_i == 2'h0) ? conv3_req_i : c3_r[lag_i - 2'h1];
endmodule // tpso_host_model

// [tb/tb_top.sv]
// self-checking bench for the trimmed power-on sequence option block
`timescale 1ns/1ps
`include "tpso_defs.svh"

module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned DIV = 4;          // short tick keeps the run brief
  logic                     ref_clk = 1'b0;  // 200 MHz
  logic                     resetn  = 1'b0;  // async reset, active low
  logic [1:0]               trim    = 2'h0;  // option strap
  logic                     pwr_on  = 1'b0;  // power-on request
  logic                     pwr_off = 1'b0;  // power-off request
  logic                     chg     = 1'b0;  // charger supply present
  logic [3:0]               addr    = 4'h0;  // register address
  logic [7:0]               wdata   = 8'h00; // register write data
  logic                     wr      = 1'b0;  // write strobe
  logic                     rd      = 1'b0;  // read strobe
  logic                     c12_req = 1'b0;  // host wish for converter12
  logic                     c3_req  = 1'b0;  // host wish for converter3
  logic [1:0]               lag     = 2'h0;  // host answer delay
  logic                     c12_pin;         // converter12 pin
  logic                     c3_pin;          // converter3 pin
  logic [7:0]               rdata;           // read data
  tpso_pkg::tpso_rails_type rails;           // rail enables
  logic                     sys_rst_n;       // system reset out, active low
  logic [2:0]               ldo_on;          // linear regulator on bits
  logic [3:0]               ilim;            // input current limit
  logic [3:0]               ichg;            // charge current setting
  int                       fail_count = 0;  // mismatches
  int                       checks     = 0;  // comparisons
  int                       cycles     = 0;  // watchdog count
  logic [7:0]               d;               // scratch read value
  time                      t0;              // start of power-on
  logic                     is3;             // option three
  logic                     is4;             // option four

  always #2.5 ref_clk = ~ref_clk;

  tpso_top #(.TICK_DIV(DIV)) DUT (
    .REF_CLK_I(ref_clk), .RESETN_I(resetn), .TRIM_SEL_I(trim), .PWR_ON_REQ_I(pwr_on),
    .PWR_OFF_REQ_I(pwr_off), .CHG_SUPPLY_I(chg), .CONV12_EN_IN_I(c12_pin),
    .CONV3_EN_IN_I(c3_pin), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .RAILS_O(rails), .SYS_RESET_N_O(sys_rst_n), .LDO_ON_O(ldo_on),
    .ILIM_O(ilim), .ICHG_O(ichg));

  tpso_host_model host (
    .clk_i(ref_clk), .resetn_i(resetn), .lag_i(lag), .conv12_req_i(c12_req),
    .conv3_req_i(c3_req), .conv12_en_o(c12_pin), .conv3_en_o(c3_pin));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one comparison; four-state equality so an unknown never matches
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask

  // option strap is only looked at while reset lets go
  task automatic do_reset(input logic [1:0] o);
    @(posedge ref_clk);
    resetn <= 1'b0;
    trim   <= o;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // watchdog
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("unexpected at %0t: run hangs", $time);
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // tests, one pass for each trimmed option
  // ----------------------------------------------------------------
  initial
  begin
    for (int o = 0; o < 4; o++)
    begin
      is3 = (o == 2);
      is4 = (o == 3);
      do_reset(o[1:0]);
      chk(ldo_on, is4 ? 8'h00 : 8'h07, "ldo on default");
      chk(ilim, is3 ? 8'h09 : 8'h05, "ilim default");
      chk(ichg, is3 ? 8'h08 : 8'h04, "ichg default");
      rd_reg(4'h3, d);
      chk(d[4:3], o[1:0], "option in status");
      chk(d[2:0], 8'h01, "state off");
      rd_reg(4'h2, d);
      chk(d, is3 ? 8'h08 : 8'h04, "ichg read");
      chk(rails.lreg2, is4, "lreg2 before start");
      chk(rails.vref, is4, "vref before start");
      if (o == 0)
      begin
        // writes every other cycle, one to the read-only place, then an unmapped read
        wr_reg(`TPSO_ADDR_ILIM, 8'h09);
        wr_reg(`TPSO_ADDR_ICHG, 8'h08);
        wr_reg(`TPSO_ADDR_STATUS, 8'hFF);
        wr_reg(`TPSO_ADDR_LDO_ON, 8'hFA);
        rd_reg(`TPSO_ADDR_ILIM, d);
        chk(d, 8'h09, "ilim read back");
        chk(ichg, 8'h08, "ichg written");
        chk(ldo_on, 8'h02, "ldo on written");
        rd_reg(`TPSO_ADDR_LDO_ON, d);
        chk(d, 8'h02, "ldo on read back");
        rd_reg(`TPSO_ADDR_STATUS, d);
        chk(d[2:0], 8'h01, "status not writable");
        rd_reg(4'hF, d);
        chk(d, 8'h00, "unmapped read");
      end
      // charger insertion; option four must refuse it
      @(posedge ref_clk);
      chg <= 1'b1;
      t0 = $time;
      repeat (3) @(posedge ref_clk);
      #1 chk(rails.lreg2, is4, "lreg2 not before its step");
      rd_reg(4'h3, d);
      chk(d[2:0], is4 ? 8'h01 : 8'h02, "charger start");
      if (is4)
      begin
        @(posedge ref_clk);
        pwr_on <= 1'b1;
        t0 = $time;
        @(posedge ref_clk);
        pwr_on <= 1'b0;
      end
      // host pins low: not yet valid, so converters follow the sequence
      repeat (30) @(posedge ref_clk);
      #1 chk(rails.conv12, 1'b1, "conv12 pin ignored early");
      chk(rails.conv3, 1'b1, "conv3 pin ignored early");
      chk(rails.lreg2, 1'b1, "lreg2 in sequence");
      chk(rails.vref, 1'b1, "vref in sequence");
      while (sys_rst_n !== 1'b1 && cycles < 19000) @(posedge ref_clk);
      chk((($time - t0) / 5 >= 40 * DIV - 4) && (($time - t0) / 5 <= 40 * DIV + 8), 1'b1,
          "reset release time");
      repeat (2) @(posedge ref_clk);
      #1 chk(rails.conv12, o == 0, "conv12 after release");
      chk(rails.conv3, !is4, "conv3 after release");
      if (o == 0)
      begin
        // 77 ticks from the start make the pin valid
        repeat (37 * DIV + 12) @(posedge ref_clk);
        #1 chk(rails.conv12, 1'b0, "conv12 valid after 2ms");
      end
      // host raises both pins, slower for each option; changed at an edge
      @(posedge ref_clk);
      lag     <= o[1:0];
      c12_req <= 1'b1;
      c3_req  <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1 chk(rails.conv12, 1'b1, "conv12 follows pin");
      chk(rails.conv3, 1'b1, "conv3 follows pin");
      // power off: reference and regulator two stay only under option four
      @(posedge ref_clk);
      pwr_off <= 1'b1;
      @(posedge ref_clk);
      pwr_off <= 1'b0;
      chg     <= 1'b0;
      c12_req <= 1'b0;
      c3_req  <= 1'b0;
      #1 chk(rails.conv12, 1'b0, "conv12 off");
      chk(rails.conv3, 1'b0, "conv3 off");
      chk(rails.lreg2, is4, "lreg2 after off");
      chk(rails.vref, is4, "vref after off");
      chk(sys_rst_n, 1'b0, "reset asserted after off");
    end
    summarize();
  end
endmodule // tb_top
